// ### inc/sts_cfg.svh
// Constants for the source transfer sequencer: offsets, fields, resets, timing
`ifndef STS_CFG_SVH
`define STS_CFG_SVH

// Register offsets (byte addresses)
`define STS_OFF_CTRL 8'h00
`define STS_OFF_TOE_DLY 8'h04
`define STS_OFF_TON_DLY 8'h08
`define STS_OFF_COOL_DLY 8'h0C
`define STS_OFF_STATUS 8'h10

// Control fields
`define STS_CTRL_THREE_PHASE 0
`define STS_CTRL_PROG_TRANS 1
`define STS_CTRL_RST 2'h0

// Status fields
`define STS_STAT_STATE_LSB 0
`define STS_STAT_NORM_OK 3
`define STS_STAT_EMERG_OK 4
`define STS_STAT_GEN_START 5
`define STS_STAT_EMERG_CMD 6
`define STS_STAT_NORM_CMD 7
`define STS_STAT_INHIBIT 8
`define STS_STAT_TEST 9

// Adjustable delay resets, in milliseconds
`define STS_TOE_DLY_RST 16'h03E8
`define STS_TON_DLY_RST 16'h03E8
`define STS_COOL_DLY_RST 16'h1388

// Sense thresholds, percent of rated
`define STS_NORM_DROPOUT_PCT 7'h46
`define STS_NORM_PICKUP_PCT 7'h5A
`define STS_EMERG_VOLT_PCT 7'h55
`define STS_EMERG_FREQ_PCT 7'h5F

// Timing: clock rate, tick length and fixed delays in milliseconds
`define STS_CLK_KHZ 100000
`define STS_TICK_MS 1
`define STS_TICK_CYCLES (`STS_TICK_MS * `STS_CLK_KHZ)
`define STS_ENG_START_MS 20'h00BB8
`define STS_RETRANSFER_MS 20'h493E0
`define STS_ENG_START_TICKS (`STS_ENG_START_MS / `STS_TICK_MS)
`define STS_RETRANSFER_TICKS (`STS_RETRANSFER_MS / `STS_TICK_MS)

`endif

// ### inc/sts_pkg.sv
// Types for the source transfer sequencer
package sts_pkg;

  // Gray coded along the failure, transfer and return path when programmed transition is on
  typedef enum logic [2:0] {
    STS_IDLE = 3'h0,
    STS_START_DLY = 3'h1,
    STS_WAIT_EMERG = 3'h3,
    STS_OFF_TO_EMERG = 3'h2,
    STS_ON_EMERG = 3'h6,
    STS_RETRANSFER = 3'h7,
    STS_OFF_TO_NORM = 3'h5,
    STS_COOLDOWN = 3'h4
  } sts_state_t;

endpackage : sts_pkg

// ### rtl/sts_sequencer.sv
// Source transfer sequencer: sensing, delays, transfer commands and lamps
//
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "sts_cfg.svh"

module sts_sequencer #(
  parameter int TICK_CYCLES = `STS_TICK_CYCLES
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic [6:0] norm_volt_a_i,
  input wire logic [6:0] norm_volt_b_i,
  input wire logic [6:0] norm_volt_c_i,
  input wire logic [6:0] emerg_volt_i,
  input wire logic [6:0] emerg_freq_i,
  input wire logic test_i,
  input wire logic inhibit_i,
  input wire logic normal_position_feedback_i,
  input wire logic emergency_position_feedback_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rd_data_o,
  output logic gen_start_o,
  output logic emergency_transfer_cmd_o,
  output logic normal_transfer_cmd_o,
  output logic norm_pos_lamp_o,
  output logic emerg_pos_lamp_o,
  output logic norm_avail_lamp_o,
  output logic emerg_avail_lamp_o
);

  sts_pkg::sts_state_t state;
  sts_pkg::sts_state_t next_state;

  logic [1:0] ctrl;
  logic [15:0] toe_dly;
  logic [15:0] ton_dly;
  logic [15:0] cool_dly;
  logic [3:0] sync_a;
  logic [3:0] sync_b;
  logic test_s;
  logic inhibit_s;
  logic norm_pos_s;
  logic emerg_pos_s;
  logic [6:0] volt_a;
  logic [6:0] volt_b;
  logic [6:0] volt_c;
  logic [6:0] e_volt;
  logic [6:0] e_freq;
  logic norm_ok;
  logic emerg_ok;
  logic three_phase;
  logic prog_trans;
  logic [31:0] pre_cnt;
  logic tick;
  logic [19:0] timer;
  logic timer_done;
  logic [19:0] target;
  logic norm_eff;

  assign three_phase = ctrl[`STS_CTRL_THREE_PHASE];
  assign prog_trans = ctrl[`STS_CTRL_PROG_TRANS];

  // Two-flop synchronisers; only the second stage is used by the logic
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      sync_a <= 4'h0;
      sync_b <= 4'h0;
    end else begin
      sync_a <= {emergency_position_feedback_i, normal_position_feedback_i,
                 inhibit_i, test_i};
      sync_b <= sync_a;
    end
  end
  assign test_s = sync_b[0];
  assign inhibit_s = sync_b[1];
  assign norm_pos_s = sync_b[2];
  assign emerg_pos_s = sync_b[3];

  // Sensed levels registered once
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      volt_a <= 7'h00;
      volt_b <= 7'h00;
      volt_c <= 7'h00;
      e_volt <= 7'h00;
      e_freq <= 7'h00;
    end else begin
      volt_a <= norm_volt_a_i;
      volt_b <= norm_volt_b_i;
      volt_c <= norm_volt_c_i;
      e_volt <= emerg_volt_i;
      e_freq <= emerg_freq_i;
    end
  end

  // Normal acceptance with hysteresis; the test switch forces normal unaccepted, emergency sensing carries on
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      norm_ok <= 1'b0;
    end else if (test_s) begin
      norm_ok <= 1'b0;
    end else if (norm_ok) begin
      if (volt_a < `STS_NORM_DROPOUT_PCT ||
          (three_phase && (volt_b < `STS_NORM_DROPOUT_PCT ||
                           volt_c < `STS_NORM_DROPOUT_PCT))) begin
        norm_ok <= 1'b0;
      end
    end else if (volt_a > `STS_NORM_PICKUP_PCT &&
                 (!three_phase || (volt_b > `STS_NORM_PICKUP_PCT &&
                                   volt_c > `STS_NORM_PICKUP_PCT))) begin
      norm_ok <= 1'b1;
    end
  end

  // Emergency accepted as soon as both levels are met, no qualification wait
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      emerg_ok <= 1'b0;
    end else begin
      emerg_ok <= (e_volt >= `STS_EMERG_VOLT_PCT) &&
                  (e_freq >= `STS_EMERG_FREQ_PCT);
    end
  end

  // Register writes
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      ctrl <= `STS_CTRL_RST;
      toe_dly <= `STS_TOE_DLY_RST;
      ton_dly <= `STS_TON_DLY_RST;
      cool_dly <= `STS_COOL_DLY_RST;
    end else if (wr_i) begin
      case (addr_i)
        `STS_OFF_CTRL: ctrl <= wr_data_i[1:0];
        `STS_OFF_TOE_DLY: toe_dly <= wr_data_i[15:0];
        `STS_OFF_TON_DLY: ton_dly <= wr_data_i[15:0];
        `STS_OFF_COOL_DLY: cool_dly <= wr_data_i[15:0];
        default: ;
      endcase
    end
  end

  // Read data stands only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      rd_data_o <= 32'h0000_0000;
    end else if (rd_i) begin
      case (addr_i)
        `STS_OFF_CTRL: rd_data_o <= {30'h0000_0000, ctrl};
        `STS_OFF_TOE_DLY: rd_data_o <= {16'h0000, toe_dly};
        `STS_OFF_TON_DLY: rd_data_o <= {16'h0000, ton_dly};
        `STS_OFF_COOL_DLY: rd_data_o <= {16'h0000, cool_dly};
        `STS_OFF_STATUS: rd_data_o <= {22'h00_0000, test_s, inhibit_s,
                                       normal_transfer_cmd_o, emergency_transfer_cmd_o,
                                       gen_start_o, emerg_ok, norm_ok, state};
        default: rd_data_o <= 32'h0000_0000;
      endcase
    end else begin
      rd_data_o <= 32'h0000_0000;
    end
  end

  // Millisecond prescaler; a parameter so simulation can shorten it
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      pre_cnt <= 32'h0000_0000;
      tick <= 1'b0;
    end else if (pre_cnt >= 32'(TICK_CYCLES - 1)) begin
      pre_cnt <= 32'h0000_0000;
      tick <= 1'b1;
    end else begin
      pre_cnt <= pre_cnt + 32'h0000_0001;
      tick <= 1'b0;
    end
  end

  // Delay target for the timed states
  always_comb begin
    case (state)
      sts_pkg::STS_START_DLY: target = 20'(`STS_ENG_START_TICKS);
      sts_pkg::STS_RETRANSFER: target = 20'(`STS_RETRANSFER_TICKS);
      sts_pkg::STS_OFF_TO_EMERG: target = {4'h0, toe_dly};
      sts_pkg::STS_OFF_TO_NORM: target = {4'h0, ton_dly};
      sts_pkg::STS_COOLDOWN: target = {4'h0, cool_dly};
      default: target = 20'h00000;
    endcase
  end
  assign timer_done = (timer >= target);

  // One shared timer, cleared on every state change so a cancelled delay restarts from zero
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      timer <= 20'h00000;
    end else if (next_state != state) begin
      timer <= 20'h00000;
    end else if (tick && !timer_done) begin
      timer <= timer + 20'h00001;
    end
  end

  // Normal treated as failed while in test
  assign norm_eff = norm_ok && !test_s;

  always_comb begin
    next_state = state;
    case (state)
      sts_pkg::STS_IDLE: begin
        if (!norm_eff && norm_pos_s) begin
          next_state = sts_pkg::STS_START_DLY;
        end
      end
      sts_pkg::STS_START_DLY: begin
        if (norm_eff) begin
          next_state = sts_pkg::STS_IDLE;
        end else if (timer_done) begin
          next_state = sts_pkg::STS_WAIT_EMERG;
        end
      end
      sts_pkg::STS_WAIT_EMERG: begin
        if (norm_eff) begin
          next_state = sts_pkg::STS_COOLDOWN;
        end else if (emerg_ok && !inhibit_s) begin
          next_state = prog_trans ? sts_pkg::STS_OFF_TO_EMERG
                                  : sts_pkg::STS_ON_EMERG;
        end
      end
      sts_pkg::STS_OFF_TO_EMERG: begin
        if (timer_done) begin
          next_state = sts_pkg::STS_ON_EMERG;
        end
      end
      sts_pkg::STS_ON_EMERG: begin
        if (norm_eff) begin
          next_state = sts_pkg::STS_RETRANSFER;
        end
      end
      sts_pkg::STS_RETRANSFER: begin
        if (!norm_eff) begin
          next_state = sts_pkg::STS_ON_EMERG;
        end else if (!emerg_ok) begin
          next_state = sts_pkg::STS_COOLDOWN;
        end else if (timer_done && !inhibit_s) begin
          next_state = prog_trans ? sts_pkg::STS_OFF_TO_NORM
                                  : sts_pkg::STS_COOLDOWN;
        end
      end
      sts_pkg::STS_OFF_TO_NORM: begin
        if (timer_done) begin
          next_state = sts_pkg::STS_COOLDOWN;
        end
      end
      sts_pkg::STS_COOLDOWN: begin
        if (timer_done) begin
          next_state = sts_pkg::STS_IDLE;
        end
      end
      default: next_state = sts_pkg::STS_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      state <= sts_pkg::STS_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Generator start: raised only from normal position, held until cooldown ends
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      gen_start_o <= 1'b0;
    end else if (state == sts_pkg::STS_START_DLY &&
                 next_state == sts_pkg::STS_WAIT_EMERG && norm_pos_s) begin
      gen_start_o <= 1'b1;
    end else if (state == sts_pkg::STS_COOLDOWN && timer_done) begin
      gen_start_o <= 1'b0;
    end
  end

  // Transfer commands follow the next state; both low while held off
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      emergency_transfer_cmd_o <= 1'b0;
      normal_transfer_cmd_o <= 1'b1;
    end else begin
      emergency_transfer_cmd_o <= (next_state == sts_pkg::STS_ON_EMERG) ||
                                  (next_state == sts_pkg::STS_RETRANSFER);
      normal_transfer_cmd_o <= (next_state == sts_pkg::STS_IDLE) ||
                               (next_state == sts_pkg::STS_START_DLY) ||
                               (next_state == sts_pkg::STS_WAIT_EMERG) ||
                               (next_state == sts_pkg::STS_COOLDOWN);
    end
  end

  // Lamps driven from synchronised feedback and acceptance flags
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      norm_pos_lamp_o <= 1'b0;
      emerg_pos_lamp_o <= 1'b0;
      norm_avail_lamp_o <= 1'b0;
      emerg_avail_lamp_o <= 1'b0;
    end else begin
      norm_pos_lamp_o <= norm_pos_s;
      emerg_pos_lamp_o <= emerg_pos_s;
      norm_avail_lamp_o <= norm_ok;
      emerg_avail_lamp_o <= emerg_ok;
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);

  a_start_from_normal: assert property (
    $rose(gen_start_o) |-> $past(norm_pos_s)
  ) else $error("generator start raised off normal position");

  a_start_cancel: assert property (
    (state == sts_pkg::STS_START_DLY && norm_eff) |=>
      (state == sts_pkg::STS_IDLE && timer == 20'h00000 && !gen_start_o)
  ) else $error("start delay not cancelled");

  a_drop_starts_timer: assert property (
    (state == sts_pkg::STS_IDLE && !norm_eff && norm_pos_s) |=>
      (state == sts_pkg::STS_START_DLY && timer == 20'h00000)
  ) else $error("normal loss did not start delay");

  a_emerg_immediate: assert property (
    (state == sts_pkg::STS_WAIT_EMERG && emerg_ok && !norm_eff && !inhibit_s &&
     !prog_trans) |=> ##0 emergency_transfer_cmd_o && !normal_transfer_cmd_o
  ) else $error("emergency transfer delayed");

  a_cmds_exclusive: assert property (
    !(emergency_transfer_cmd_o && normal_transfer_cmd_o)
  ) else $error("both transfer commands high");

  a_hyst_hold: assert property (
    (norm_ok && !test_s && !three_phase && volt_a >= `STS_NORM_DROPOUT_PCT) |=> norm_ok
  ) else $error("normal dropped above dropout");

  a_emerg_levels: assert property (
    emerg_ok |-> ($past(e_volt) >= `STS_EMERG_VOLT_PCT && $past(e_freq) >= `STS_EMERG_FREQ_PCT)
  ) else $error("emergency accepted below levels");

  a_retransfer_abort: assert property (
    (state == sts_pkg::STS_RETRANSFER && norm_eff && !emerg_ok) |=>
      ##0 normal_transfer_cmd_o && !emergency_transfer_cmd_o
  ) else $error("no immediate retransfer on emergency loss");

  a_test_fails_normal: assert property (
    test_s |=> !norm_ok
  ) else $error("test did not fail normal");

  a_inhibit_holds: assert property (
    (state == sts_pkg::STS_WAIT_EMERG && inhibit_s && !norm_eff) |=>
      !emergency_transfer_cmd_o
  ) else $error("transfer under inhibit");

  a_lamp_follow: assert property (
    emerg_pos_lamp_o == $past(emerg_pos_s)
  ) else $error("emergency position lamp wrong");

  c_gen_start: cover property ($rose(gen_start_o));
  c_to_emerg: cover property ($rose(emergency_transfer_cmd_o));
  c_back_idle: cover property (state == sts_pkg::STS_COOLDOWN ##1 state == sts_pkg::STS_IDLE);
  c_retransfer_abort: cover property (state == sts_pkg::STS_RETRANSFER && !emerg_ok && norm_eff);

endmodule : sts_sequencer

// ### tb/sts_switch_model.sv
// Power switching device and generator set behavioural model
`timescale 1ns/1ps

module sts_switch_model (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic gen_start_i,
  input wire logic gen_fail_i,
  input wire logic emergency_transfer_cmd_i,
  input wire logic normal_transfer_cmd_i,
  output logic [6:0] emerg_volt_o,
  output logic [6:0] emerg_freq_o,
  output logic normal_position_feedback_o,
  output logic emergency_position_feedback_o
);
  logic [4:0] run_cnt;
  logic [1:0] norm_mech;
  logic [1:0] emerg_mech;

  // Engine needs some cycles to come up to speed; a stopped engine gives no voltage
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i || !gen_start_i) begin
      run_cnt <= 5'h00;
    end else if (run_cnt != 5'h1F) begin
      run_cnt <= run_cnt + 5'h01;
    end
  end
  assign emerg_volt_o = (run_cnt > 5'h14 && !gen_fail_i) ? 7'h64 : 7'h00;
  assign emerg_freq_o = (run_cnt > 5'h14 && !gen_fail_i) ? 7'h64 : 7'h00;

  // Contacts follow the commands after two cycles; both low leaves the switch off
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      norm_mech <= 2'h3;
      emerg_mech <= 2'h0;
    end else begin
      norm_mech <= {norm_mech[0], normal_transfer_cmd_i};
      emerg_mech <= {emerg_mech[0], emergency_transfer_cmd_i};
    end
  end
  assign normal_position_feedback_o = norm_mech[1];
  assign emergency_position_feedback_o = emerg_mech[1];
endmodule : sts_switch_model

// ### tb/tb_sts_sequencer.sv
// Self-checking testbench for the source transfer sequencer
`timescale 1ns/1ps

module tb_sts_sequencer;
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [6:0] va = 7'h5F;
  logic [6:0] vb = 7'h5F;
  logic [6:0] vc = 7'h5F;
  logic [6:0] ev, ef;
  logic test_i = 1'b0;
  logic inhibit_i = 1'b0;
  logic gen_fail = 1'b0;
  logic npf, epf;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wr_data_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [31:0] rd_data_o;
  logic gen_start_o, ecmd, ncmd, npl, epl, nal, eal;
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc_cnt = 0;
  int n;
  logic [31:0] d;
  logic [7:0] rst_addr [5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h14};
  logic [31:0] rst_val [5] = '{32'h0, 32'h3E8, 32'h3E8, 32'h1388, 32'h0};

  initial begin
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  // Tick shortened to two cycles: 3 s start delay is 6000 cycles
  sts_sequencer #(.TICK_CYCLES(2)) i_dut (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .norm_volt_a_i(va), .norm_volt_b_i(vb), .norm_volt_c_i(vc),
    .emerg_volt_i(ev), .emerg_freq_i(ef), .test_i(test_i), .inhibit_i(inhibit_i),
    .normal_position_feedback_i(npf), .emergency_position_feedback_i(epf),
    .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i),
    .rd_data_o(rd_data_o), .gen_start_o(gen_start_o),
    .emergency_transfer_cmd_o(ecmd), .normal_transfer_cmd_o(ncmd),
    .norm_pos_lamp_o(npl), .emerg_pos_lamp_o(epl),
    .norm_avail_lamp_o(nal), .emerg_avail_lamp_o(eal)
  );

  sts_switch_model i_model (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .gen_start_i(gen_start_o),
    .gen_fail_i(gen_fail), .emergency_transfer_cmd_i(ecmd), .normal_transfer_cmd_i(ncmd),
    .emerg_volt_o(ev), .emerg_freq_o(ef),
    .normal_position_feedback_o(npf), .emergency_position_feedback_o(epf)
  );

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict

  // A hang must not run forever
  always @(posedge clk_sys_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 60000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic wait_cyc(input int k);
    repeat (k) @(posedge clk_sys_i);
    #1;
  endtask : wait_cyc

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys_i);
    addr_i <= a;
    wr_data_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask : wr

  // Read data stands only in the cycle after the read edge
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1;
    v = rd_data_o;
  endtask : rd

  task automatic chk_state(input logic [2:0] exp);
    logic [31:0] s;
    rd(8'h10, s);
    chk("state", {29'h0, s[2:0]}, {29'h0, exp});
  endtask : chk_state

  task automatic set_norm(input logic [6:0] v);
    @(posedge clk_sys_i);
    va <= v;
    vb <= v;
    vc <= v;
  endtask : set_norm

  function automatic logic pick(input int sel);
    return (sel == 0) ? gen_start_o : (sel == 1) ? ecmd : ncmd;
  endfunction : pick

  task automatic wait_out(input int sel, input logic v, output int k);
    k = 0;
    while (pick(sel) !== v && k < 20000) begin
      wait_cyc(1);
      k++;
    end
  endtask : wait_out

  // Loss with inhibit held, transfer on release, return through emergency failure
  // Early is how many cycles of the start delay ran before this task began waiting
  task automatic fail_and_return(input int off_cycles, input int early);
    wait_out(0, 1'b1, n);
    chk("start delay", n >= 5995 - early && n <= 6015 - early, 1);
    wait_cyc(100);
    chk("emerg avail", eal, 1);
    chk("held cmd", ecmd, 1'b0);
    chk_state(3'h3);
    @(posedge clk_sys_i);
    inhibit_i <= 1'b0;
    wait_out(2, 1'b0, n);
    chk("release lag", n, 3);
    wait_out(1, 1'b1, n);
    chk("to emerg", n >= off_cycles && n <= off_cycles + 8, 1);
    chk("norm cmd", ncmd, 0);
    wait_cyc(20);
    chk("emerg lamp", {npl, epl}, 2'b01);
    set_norm(7'h50);
    test_i <= 1'b0;
    wait_cyc(100);
    chk_state(3'h6);
    set_norm(7'h5F);
    wait_cyc(2000);
    chk_state(3'h7);
    chk("no early ret", ncmd, 0);
    gen_fail <= 1'b1;
    wait_out(2, 1'b1, n);
    chk("fast ret", n <= 40, 1);
    chk("emerg cmd off", ecmd, 0);
    wait_out(0, 1'b0, n);
    chk("cooldown", n >= 95 && n <= 200, 1);
    chk_state(3'h0);
    gen_fail <= 1'b0;
  endtask : fail_and_return

  initial begin
    repeat (10) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    wait_cyc(1);
    chk("reset cmds", {ncmd, ecmd, gen_start_o}, 3'b100);
    for (int i = 0; i < 5; i++) begin
      rd(rst_addr[i], d);
      chk("reset reg", d, rst_val[i]);
    end
    wr(8'h0C, 32'h32);
    wr(8'h04, 32'h19);
    rd(8'h0C, d);
    chk("cooldown reg", d, 32'h32);
    set_norm(7'h50);
    wait_cyc(20);
    chk("hyst held", nal, 1);
    chk_state(3'h0);
    set_norm(7'h41);
    wait_cyc(20);
    chk("lost", nal, 0);
    chk_state(3'h1);
    set_norm(7'h50);
    wait_cyc(2000);
    chk("below pickup", nal, 0);
    set_norm(7'h5F);
    wait_cyc(20);
    chk_state(3'h0);
    chk("no start", gen_start_o, 0);
    set_norm(7'h41);
    inhibit_i <= 1'b1;
    fail_and_return(0, 0);
    wr(8'h00, 32'h2);
    @(posedge clk_sys_i);
    test_i <= 1'b1;
    inhibit_i <= 1'b1;
    wait_cyc(20);
    rd(8'h10, d);
    chk("test state", {d[9], d[2:0]}, 4'h9);
    fail_and_return(50, 22);
    wr(8'h00, 32'h0);
    @(posedge clk_sys_i);
    vb <= 7'h41;
    wait_cyc(20);
    chk_state(3'h0);
    wr(8'h00, 32'h1);
    wait_cyc(20);
    chk_state(3'h1);
    @(posedge clk_sys_i);
    vb <= 7'h5F;
    wait_cyc(20);
    chk_state(3'h0);
    print_verdict();
  end
endmodule : tb_sts_sequencer
